// file: ctu_pkg.sv
// Constants and types for the host-side curve and gain table uploader
package ctu_pkg;
  // ----------------------------------------------------------------
  // Index, count and length bounds
  // ----------------------------------------------------------------
  localparam logic [7:0] CURVE_IDX_MIN = 8'h01;
  localparam logic [7:0] CURVE_IDX_MAX = 8'h04;
  localparam logic [7:0] TABLE_IDX_MAX = 8'h05;
  localparam logic [7:0] SENSOR_IDX_MAX = 8'h03;
  localparam logic [7:0] CURVE_ENT_MIN = 8'h02;
  localparam logic [7:0] CURVE_ENT_MAX = 8'hc8;
  localparam logic [7:0] TABLE_ENT_MAX = 8'h10;
  localparam logic [4:0] CURVE_NAME_MIN = 5'h04;
  localparam logic [4:0] CURVE_NAME_MAX = 5'h0f;
  localparam logic [4:0] TABLE_NAME_MAX = 5'h10;
  localparam logic [4:0] SENSOR_NAME_MAX = 5'h0f;
  localparam logic [2:0] CURVE_HDR_LINES = 3'h4;
  localparam logic [2:0] TABLE_HDR_LINES = 3'h1;
  localparam logic [2:0] UNITS_LINE = 3'h3;
  localparam logic [2:0] TABLE_FIELDS = 3'h5;
  // ----------------------------------------------------------------
  // Character codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_NL = 8'h0a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_QUOTE = 8'h22;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_TAB = 8'h09;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CASE_BIT = 8'h20;
  localparam logic [7:0] CH_O = 8'h6f;
  localparam logic [7:0] CH_V = 8'h76;
  localparam logic [7:0] CH_L = 8'h6c;
  localparam logic [7:0] CH_H = 8'h68;
  localparam logic [7:0] CH_M = 8'h6d;
  // ----------------------------------------------------------------
  // Command line images, left aligned, index digit slot left zero
  // ----------------------------------------------------------------
  localparam logic [127:0] CURVE_CMD = 128'h43414c43555220000000000000000000;
  localparam logic [127:0] TABLE_CMD = 128'h5049445441424c4520003a5441424c45;
  localparam logic [127:0] SENSOR_CMD = 128'h43414c4441544120003a4e414d452022;
  localparam logic [3:0] CURVE_CMD_LAST = 4'h7;
  localparam logic [3:0] LONG_CMD_LAST = 4'hf;
  localparam logic [3:0] CURVE_DIGIT = 4'h7;
  localparam logic [3:0] TABLE_DIGIT = 4'h9;
  localparam logic [3:0] SENSOR_DIGIT = 4'h8;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_CURVE = 2'h0,
    KIND_TABLE = 2'h1,
    KIND_SENSOR = 2'h2
  } ctu_kind_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CMD = 6'h02,
    ST_BODY = 6'h04,
    ST_QUOTE = 6'h08,
    ST_NL = 6'h10,
    ST_TERM = 6'h20
  } ctu_state_t;
  typedef struct packed {
    logic [7:0] data;
    logic eol;
  } ctu_tx_t;
  typedef struct packed {
    logic bad_index;
    logic bad_name;
    logic short_curve;
    logic bad_units;
    logic bad_entry;
    logic dropped;
  } ctu_stat_t;
endpackage

// file: ctu_host_uploader.sv
// Host-side sender of curve, gain table and sensor name uploads
// Contract
// [RULE1] Curve upload: command, index 1..4, name, type, multiplier, units, then pairs.
// [RULE2] Serial link ends each curve line with newline; GPIB adds none.
// [RULE3] A curve holds 2 to 200 entries.
// [RULE4] Curve name is 4 to 15 characters.
// [RULE5] Device maps type keyword to one of nine, diode when unknown.
// [RULE6] Device assumes multiplier minus one when unparsable.
// [RULE7] Units line is ohms, volts or log resistance.
// [RULE8] A lone semicolon line ends the curve.
// [RULE9] Device accepts gain table index 0..5 only.
// [RULE10] A gain table holds at most 16 entries.
// [RULE11] Each table entry has five fields, range always present.
// [RULE12] Serial link ends each table entry with newline; others none.
// [RULE13] Device converts numbers to 32-bit floating point.
// [RULE14] Heater range is high, middle or low.
// [RULE15] Device sorts table entries by setpoint before storing.
// [RULE16] Device discards table entries with bad numbers.
// [RULE17] Table ends with semicolon line; name line up to 16 characters.
// [RULE18] Device takes quoted rename up to 15 characters and answers name query.
// [RULE19] Entry count query reports entries held; not writable.
// [RULE20] User sensors index 0..3, factory sensors 0..60.
// [RULE21] User sensor name is sent inside double quotes.
// [RULE22] Factory sensor names are query only.
// [RULE23] Device sorts curve entries by reading and drops bad ones.
// [RULE24] Surplus entries beyond the maximum are ignored.
`timescale 1ns/1ps
module ctu_host_uploader (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire ctu_pkg::ctu_kind_t kind_i,
  input wire logic [7:0] index_i,
  input wire logic gpib_i,
  input wire logic u_valid_i,
  input wire logic [7:0] u_data_i,
  input wire logic u_last_i,
  output logic u_ready_o,
  input wire logic fin_i,
  output logic tx_valid_o,
  output ctu_pkg::ctu_tx_t tx_o,
  input wire logic tx_ready_i,
  output logic busy_o,
  output logic done_o,
  output ctu_pkg::ctu_stat_t stat_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ctu_pkg::ctu_state_t st_r, st_nxt, ret_r, ret_nxt;
  ctu_pkg::ctu_kind_t kind_r;
  ctu_pkg::ctu_tx_t tx_r, tx_nxt;
  ctu_pkg::ctu_stat_t stat_r, stat_nxt;
  logic [3:0] idx_r;
  logic gpib_r, tx_valid_r, done_r;
  logic [3:0] pos_r, pos_nxt;
  logic [2:0] line_r, line_nxt, fld_r, fld_nxt;
  logic [4:0] chr_r, chr_nxt;
  logic [7:0] ent_r, ent_nxt, rng_r, rng_nxt;
  logic ws_r;

  // Index range check per upload kind
  function automatic logic idx_ok(input ctu_pkg::ctu_kind_t k, input logic [7:0] i);
    case (k)
      ctu_pkg::KIND_CURVE: idx_ok = i >= ctu_pkg::CURVE_IDX_MIN && i <= ctu_pkg::CURVE_IDX_MAX;
      ctu_pkg::KIND_TABLE: idx_ok = i <= ctu_pkg::TABLE_IDX_MAX;
      default: idx_ok = i <= ctu_pkg::SENSOR_IDX_MAX;
    endcase
  endfunction

  // Fold a letter to lower case
  function automatic logic [7:0] low(input logic [7:0] c);
    low = c | ctu_pkg::CASE_BIT;
  endfunction

  // ----------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------
  wire is_curve = kind_r == ctu_pkg::KIND_CURVE;
  wire is_sensor = kind_r == ctu_pkg::KIND_SENSOR;
  wire tx_free = !tx_valid_r || tx_ready_i;
  wire [127:0] cmd_img = is_curve ? ctu_pkg::CURVE_CMD :
                         (is_sensor ? ctu_pkg::SENSOR_CMD : ctu_pkg::TABLE_CMD);
  wire [3:0] cmd_last = is_curve ? ctu_pkg::CURVE_CMD_LAST : ctu_pkg::LONG_CMD_LAST;
  wire [3:0] dig_pos = is_curve ? ctu_pkg::CURVE_DIGIT :
                       (is_sensor ? ctu_pkg::SENSOR_DIGIT : ctu_pkg::TABLE_DIGIT);
  wire [7:0] cmd_byte = (pos_r == dig_pos) ? ctu_pkg::CH_ZERO + {4'h0, idx_r} :
                        cmd_img[8'd127 - {1'b0, pos_r, 3'b000} -: 8];
  wire at_cmd_end = pos_r == cmd_last;
  wire [2:0] hdr_lines = is_curve ? ctu_pkg::CURVE_HDR_LINES : ctu_pkg::TABLE_HDR_LINES;
  wire [7:0] ent_max = is_curve ? ctu_pkg::CURVE_ENT_MAX : ctu_pkg::TABLE_ENT_MAX;
  wire [4:0] name_max = is_curve ? ctu_pkg::CURVE_NAME_MAX :
                        (is_sensor ? ctu_pkg::SENSOR_NAME_MAX : ctu_pkg::TABLE_NAME_MAX);
  wire name_line = line_r == 3'h0;
  wire entry_line = !is_sensor && line_r >= hdr_lines;
  wire drop_w = entry_line && ent_r >= ent_max; // RULE24
  wire trunc_w = name_line && chr_r >= name_max - 5'h01 && !u_last_i; // RULE4
  wire swallow = drop_w || trunc_w;
  wire u_hs = u_valid_i && u_ready_o;
  wire is_ws = u_data_i == ctu_pkg::CH_SPACE || u_data_i == ctu_pkg::CH_TAB;
  wire fld_start = !is_ws && (chr_r == 5'h00 || ws_r);
  wire [2:0] fld_now = fld_r + {2'b00, fld_start};
  wire [7:0] rng_now = fld_start ? low(u_data_i) : rng_r;
  wire rng_ok = rng_now == ctu_pkg::CH_H || rng_now == ctu_pkg::CH_M || rng_now == ctu_pkg::CH_L;
  wire unit_ok = low(u_data_i) == ctu_pkg::CH_O || low(u_data_i) == ctu_pkg::CH_V ||
                 low(u_data_i) == ctu_pkg::CH_L;
  wire [4:0] name_len = chr_r + 5'h01;
  wire fin_ok = fin_i && chr_r == 5'h00 && !is_sensor;

  // Body intake: stalls on a busy link unless the byte is swallowed
  assign u_ready_o = (st_r == ctu_pkg::ST_BODY) && (tx_free || swallow);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    ret_nxt = ret_r;
    tx_nxt = tx_r;
    stat_nxt = stat_r;
    pos_nxt = pos_r;
    line_nxt = line_r;
    chr_nxt = chr_r;
    fld_nxt = fld_r;
    ent_nxt = ent_r;
    rng_nxt = rng_r;
    case (st_r)
      ctu_pkg::ST_IDLE: begin
        if (start_i) begin
          stat_nxt = '0;
          pos_nxt = 4'h0;
          line_nxt = 3'h0;
          chr_nxt = 5'h0;
          fld_nxt = 3'h0;
          ent_nxt = 8'h00;
          if (idx_ok(kind_i, index_i)) begin // RULE1 RULE9 RULE20
            st_nxt = ctu_pkg::ST_CMD;
          end else begin
            stat_nxt.bad_index = 1'b1;
          end
        end
      end
      ctu_pkg::ST_CMD: begin
        if (tx_free) begin
          tx_nxt.data = cmd_byte;
          tx_nxt.eol = gpib_r && at_cmd_end && !is_sensor; // RULE2 RULE12
          pos_nxt = pos_r + 4'h1;
          if (at_cmd_end) begin
            ret_nxt = ctu_pkg::ST_BODY;
            st_nxt = (gpib_r || is_sensor) ? ctu_pkg::ST_BODY : ctu_pkg::ST_NL;
          end
        end
      end
      ctu_pkg::ST_BODY: begin
        if (fin_ok) begin
          if (is_curve && ent_r < ctu_pkg::CURVE_ENT_MIN) begin
            stat_nxt.short_curve = 1'b1; // RULE3
          end
          st_nxt = ctu_pkg::ST_TERM;
        end else if (u_hs) begin
          if (!swallow) begin
            tx_nxt.data = u_data_i;
            tx_nxt.eol = gpib_r && u_last_i && !is_sensor; // RULE2 RULE12
          end
          if (trunc_w) begin
            stat_nxt.bad_name = 1'b1; // RULE4 RULE17 RULE18
          end
          if (drop_w) begin
            stat_nxt.dropped = 1'b1; // RULE24
          end
          if (is_curve && line_r == ctu_pkg::UNITS_LINE && chr_r == 5'h00 && !unit_ok) begin
            stat_nxt.bad_units = 1'b1; // RULE7
          end
          chr_nxt = (chr_r == 5'h1f) ? chr_r : chr_r + 5'h01;
          fld_nxt = (fld_now == 3'h7) ? fld_r : fld_now;
          rng_nxt = rng_now;
          if (u_last_i) begin
            chr_nxt = 5'h00;
            fld_nxt = 3'h0;
            line_nxt = (line_r == 3'h7) ? line_r : line_r + 3'h1;
            if (name_line && is_curve && name_len < ctu_pkg::CURVE_NAME_MIN) begin
              stat_nxt.bad_name = 1'b1; // RULE4
            end
            if (entry_line && !kind_r[0] == 1'b0 && !drop_w &&
                (fld_now != ctu_pkg::TABLE_FIELDS || !rng_ok)) begin
              stat_nxt.bad_entry = 1'b1; // RULE11 RULE14
            end
            if (entry_line && !drop_w) begin
              ent_nxt = ent_r + 8'h01; // RULE3 RULE10
            end
            ret_nxt = ctu_pkg::ST_BODY;
            if (is_sensor) begin
              st_nxt = ctu_pkg::ST_QUOTE; // RULE21
            end else if (!gpib_r && !drop_w) begin
              st_nxt = ctu_pkg::ST_NL;
            end
          end
        end
      end
      ctu_pkg::ST_QUOTE: begin
        if (tx_free) begin
          tx_nxt.data = ctu_pkg::CH_QUOTE; // RULE21
          tx_nxt.eol = gpib_r;
          ret_nxt = ctu_pkg::ST_IDLE;
          st_nxt = gpib_r ? ctu_pkg::ST_IDLE : ctu_pkg::ST_NL;
        end
      end
      ctu_pkg::ST_NL: begin
        if (tx_free) begin
          tx_nxt.data = ctu_pkg::CH_NL; // RULE2 RULE12
          tx_nxt.eol = 1'b0;
          st_nxt = ret_r;
        end
      end
      ctu_pkg::ST_TERM: begin
        if (tx_free) begin
          tx_nxt.data = ctu_pkg::CH_SEMI; // RULE8 RULE17
          tx_nxt.eol = gpib_r;
          ret_nxt = ctu_pkg::ST_IDLE;
          st_nxt = gpib_r ? ctu_pkg::ST_IDLE : ctu_pkg::ST_NL;
        end
      end
      default: st_nxt = ctu_pkg::ST_IDLE;
    endcase
  end

  // A byte goes out whenever ST_CMD, ST_QUOTE, ST_NL or ST_TERM finds the link free, or ST_BODY passes on an input byte
  wire tx_load = tx_free && (st_r == ctu_pkg::ST_CMD || st_r == ctu_pkg::ST_QUOTE ||
                 st_r == ctu_pkg::ST_NL || st_r == ctu_pkg::ST_TERM ||
                 (st_r == ctu_pkg::ST_BODY && !fin_ok && u_hs && !swallow));

  // Control registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= ctu_pkg::ST_IDLE;
      ret_r <= ctu_pkg::ST_IDLE;
      stat_r <= '0;
      pos_r <= 4'h0;
      line_r <= 3'h0;
      chr_r <= 5'h00;
      fld_r <= 3'h0;
      ent_r <= 8'h00;
      rng_r <= 8'h00;
      ws_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ret_r <= ret_nxt;
      stat_r <= stat_nxt;
      pos_r <= pos_nxt;
      line_r <= line_nxt;
      chr_r <= chr_nxt;
      fld_r <= fld_nxt;
      ent_r <= ent_nxt;
      rng_r <= rng_nxt;
      ws_r <= u_hs ? is_ws : ws_r;
      done_r <= (st_nxt == ctu_pkg::ST_IDLE) && (st_r != ctu_pkg::ST_IDLE || start_i);
    end
  end

  // Upload settings caught at start, link byte register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      kind_r <= ctu_pkg::KIND_CURVE;
      idx_r <= 4'h0;
      gpib_r <= 1'b0;
      tx_r <= '0;
      tx_valid_r <= 1'b0;
    end else begin
      if (st_r == ctu_pkg::ST_IDLE && start_i) begin
        kind_r <= kind_i;
        idx_r <= index_i[3:0];
        gpib_r <= gpib_i;
      end
      tx_r <= tx_load ? tx_nxt : tx_r;
      tx_valid_r <= tx_load || (tx_valid_r && !tx_ready_i);
    end
  end

  assign tx_valid_o = tx_valid_r;
  assign tx_o = tx_r;
  assign busy_o = st_r != ctu_pkg::ST_IDLE;
  assign done_o = done_r;
  assign stat_o = stat_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  curve_idx_a: assert property ( // RULE1
    st_r == ctu_pkg::ST_IDLE && start_i && kind_i == ctu_pkg::KIND_CURVE &&
    (index_i < ctu_pkg::CURVE_IDX_MIN || index_i > ctu_pkg::CURVE_IDX_MAX)
    |=> st_r == ctu_pkg::ST_IDLE && stat_o.bad_index && done_o)
    else $error("curve index out of range was not refused");
  table_idx_a: assert property ( // RULE9
    st_r == ctu_pkg::ST_IDLE && start_i && kind_i == ctu_pkg::KIND_TABLE &&
    index_i <= ctu_pkg::TABLE_IDX_MAX |=> st_r == ctu_pkg::ST_CMD)
    else $error("legal table index did not start a transfer");
  sensor_idx_a: assert property ( // RULE20
    st_r == ctu_pkg::ST_IDLE && start_i && kind_i == ctu_pkg::KIND_SENSOR &&
    index_i > ctu_pkg::SENSOR_IDX_MAX |=> !busy_o ##1 !busy_o)
    else $error("sensor index out of range started a transfer");
  serial_nl_a: assert property ( // RULE2
    st_r == ctu_pkg::ST_BODY && u_hs && u_last_i && !gpib_r && !is_sensor && !swallow
    && !fin_ok |=> st_r == ctu_pkg::ST_NL ##[0:1000] tx_load && tx_nxt.data == ctu_pkg::CH_NL)
    else $error("serial line end missing its newline");
  gpib_no_nl_a: assert property ( // RULE12
    gpib_r && st_r == ctu_pkg::ST_BODY |-> st_nxt != ctu_pkg::ST_NL)
    else $error("newline inserted on gpib link");
  ent_cap_a: assert property ( // RULE24
    u_hs && drop_w |=> $stable(ent_r) && !$rose(tx_valid_o) && stat_o.dropped)
    else $error("surplus entry was counted or sent");
  term_semi_a: assert property ( // RULE8
    st_r == ctu_pkg::ST_TERM && tx_free |=> tx_valid_o && tx_o.data == ctu_pkg::CH_SEMI)
    else $error("terminator line not sent");
  quote_a: assert property ( // RULE21
    st_r == ctu_pkg::ST_QUOTE && tx_free |=> tx_o.data == ctu_pkg::CH_QUOTE &&
    tx_o.eol == gpib_r)
    else $error("closing quote missing");
  short_curve_a: assert property ( // RULE3
    st_r == ctu_pkg::ST_BODY && fin_ok && is_curve && ent_r < ctu_pkg::CURVE_ENT_MIN
    |=> stat_o.short_curve && st_r == ctu_pkg::ST_TERM)
    else $error("short curve not flagged");
  fields_a: assert property ( // RULE11
    st_r == ctu_pkg::ST_BODY && !fin_ok && u_hs && u_last_i && entry_line && !is_curve &&
    !drop_w && fld_now != ctu_pkg::TABLE_FIELDS |=> stat_o.bad_entry)
    else $error("table entry with wrong field count not flagged");
  name_len_a: assert property ( // RULE4
    st_r == ctu_pkg::ST_BODY && u_hs && trunc_w |=> stat_o.bad_name && !$rose(tx_valid_o))
    else $error("overlong name byte was sent");

  cover_curve_c: cover property (st_r == ctu_pkg::ST_TERM && is_curve ##[1:20] done_o);
  cover_table_c: cover property (st_r == ctu_pkg::ST_BODY && drop_w && u_hs && !is_curve);
  cover_sensor_c: cover property (st_r == ctu_pkg::ST_QUOTE ##[1:20] done_o);
endmodule

// file: ctu_dev_model.sv
// Behavioural device end of the upload link that records every accepted byte
`timescale 1ns/1ps
module ctu_dev_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic slow_i,
  input wire logic tx_valid_i,
  input wire ctu_pkg::ctu_tx_t tx_i,
  output logic tx_ready_o
);
  ctu_pkg::ctu_tx_t rx_q[$];
  int term_cnt = 0;
  int line_len = 0;
  int line_cnt = 0;
  logic semi_r = 1'b0;
  logic [1:0] pace_r;
  wire take = tx_valid_i && tx_ready_o;
  wire is_nl = (tx_i.data == ctu_pkg::CH_NL);
  // ----------------------------------------------------------------
  // Pacing: prompt, or one acceptance in four cycles when slow
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pace_r <= 2'h0;
      tx_ready_o <= 1'b0;
    end else begin
      pace_r <= pace_r + 2'h1;
      tx_ready_o <= !slow_i || (pace_r == 2'h2);
    end
  end
  // ----------------------------------------------------------------
  // Line assembly and end-of-list detection
  // ----------------------------------------------------------------
  // A line ends at a newline byte or at a byte flagged as line end
  always @(posedge clk_i) begin
    if (rstn_i && take) begin
      rx_q.push_back(tx_i);
      if (is_nl || tx_i.eol) begin
        if ((is_nl && line_len == 1 && semi_r) ||
            (!is_nl && line_len == 0 && tx_i.data == ctu_pkg::CH_SEMI)) begin
          term_cnt++;
        end
        line_len = 0;
        line_cnt++;
      end else begin
        semi_r = (line_len == 0) && (tx_i.data == ctu_pkg::CH_SEMI);
        line_len++;
      end
    end
  end
endmodule

// file: tb.sv
// Self-checking bench for the host-side curve and gain table uploader
`timescale 1ns/1ps
module tb;
  logic clk_i, rstn_i, start_i, gpib_i, u_valid_i, u_last_i, fin_i, slow;
  logic [7:0] index_i, u_data_i;
  logic u_ready_o, tx_valid_o, tx_ready, busy_o, done_o;
  ctu_pkg::ctu_kind_t kind_i;
  ctu_pkg::ctu_tx_t tx_o;
  ctu_pkg::ctu_stat_t stat_o;
  ctu_pkg::ctu_tx_t exp_q[$];
  int failures = 0;
  int check_count = 0;
  ctu_host_uploader ctu_host_uploader_i (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i),
    .kind_i(kind_i), .index_i(index_i), .gpib_i(gpib_i), .u_valid_i(u_valid_i),
    .u_data_i(u_data_i), .u_last_i(u_last_i), .u_ready_o(u_ready_o), .fin_i(fin_i),
    .tx_valid_o(tx_valid_o), .tx_o(tx_o), .tx_ready_i(tx_ready), .busy_o(busy_o),
    .done_o(done_o), .stat_o(stat_o));
  ctu_dev_model ctu_dev_model_i (.clk_i(clk_i), .rstn_i(rstn_i), .slow_i(slow),
    .tx_valid_i(tx_valid_o), .tx_i(tx_o), .tx_ready_o(tx_ready));
  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic summarize();
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang(string what);
    failures++;
    $display("CHECK FAILED %s expected handshake seen none", what);
    summarize();
  endtask
  // ----------------------------------------------------------------
  // Drivers, all entered and left at a falling edge
  // ----------------------------------------------------------------
  task automatic do_start(ctu_pkg::ctu_kind_t k, logic [7:0] idx, logic g);
    kind_i = k;
    index_i = idx;
    gpib_i = g;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
  endtask
  // Holds each byte until the uploader is ready, leaves the last one up
  task automatic send_line(string s);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      n = 0;
      u_valid_i = 1'b1;
      u_data_i = s[i];
      u_last_i = (i == s.len() - 1);
      #1;
      while (u_ready_o !== 1'b1) begin
        @(negedge clk_i);
        #1;
        n++;
        if (n > 400) hang("u_ready_o");
      end
      @(negedge clk_i);
    end
  endtask
  // ----------------------------------------------------------------
  // Expected byte stream
  // ----------------------------------------------------------------
  task automatic exp_line(string s, logic g);
    for (int i = 0; i < s.len(); i++) begin
      exp_q.push_back(ctu_pkg::ctu_tx_t'({s[i], g && (i == s.len() - 1)}));
    end
    if (!g) exp_q.push_back(ctu_pkg::ctu_tx_t'({ctu_pkg::CH_NL, 1'b0}));
  endtask
  task automatic exp_cmd(logic [127:0] img, logic [3:0] last, logic [3:0] dig,
                         logic [7:0] idx, logic g, logic ends);
    logic [7:0] c;
    for (int i = 0; i <= int'(last); i++) begin
      c = (i == dig) ? ctu_pkg::CH_ZERO + {4'h0, idx[3:0]} : img[127 - 8 * i -: 8];
      exp_q.push_back(ctu_pkg::ctu_tx_t'({c, g && ends && (i == last)}));
    end
    if (ends && !g) exp_q.push_back(ctu_pkg::ctu_tx_t'({ctu_pkg::CH_NL, 1'b0}));
  endtask
  // Ends the body, optionally asks for the terminator, then judges it all
  task automatic finish_upload(string what, logic fin, logic [5:0] st);
    int n;
    n = 0;
    u_valid_i = 1'b0;
    u_last_i = 1'b0;
    if (fin) begin
      // Fin is taken at a body edge between lines of a curve or table, so raise it only once the body is open
      #1;
      while (u_ready_o !== 1'b1) begin
        @(negedge clk_i);
        #1;
        n++;
        if (n > 400) hang("fin");
      end
      fin_i = 1'b1;
      @(negedge clk_i);
      fin_i = 1'b0;
    end
    n = 0;
    while (done_o !== 1'b1) begin
      @(negedge clk_i);
      n++;
      if (n > 400) hang("done_o");
    end
    chk({what, " stat_o"}, st, stat_o);
    // Done comes as the last byte is loaded, so that byte is still pending
    chk({what, " tx_valid_o"}, !st[5], tx_valid_o);
    n = 0;
    while (tx_valid_o !== 1'b0) begin
      @(negedge clk_i);
      n++;
      if (n > 400) hang("tx drain");
    end
    chk({what, " length"}, exp_q.size(), ctu_dev_model_i.rx_q.size());
    for (int i = 0; i < exp_q.size() && i < ctu_dev_model_i.rx_q.size(); i++) begin
      chk({what, " byte"}, exp_q[i], ctu_dev_model_i.rx_q[i]);
    end
    exp_q.delete();
    ctu_dev_model_i.rx_q.delete();
    @(negedge clk_i);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_bad_index();
    ctu_pkg::ctu_kind_t k[4] = '{ctu_pkg::KIND_CURVE, ctu_pkg::KIND_CURVE,
                                 ctu_pkg::KIND_TABLE, ctu_pkg::KIND_SENSOR};
    logic [7:0] x[4] = '{8'h00, 8'h05, 8'h06, 8'h04};
    for (int i = 0; i < 4; i++) begin
      do_start(k[i], x[i], 1'b0);
      chk("refused done_o", 1, done_o);
      chk("refused busy_o", 0, busy_o);
      finish_upload("refused", 1'b0, 6'h20);
    end
  endtask
  task automatic sc_curve(logic [7:0] idx, logic g, string nm, string xnm, string un,
                          int n, logic [5:0] st);
    int t0;
    t0 = ctu_dev_model_i.term_cnt;
    do_start(ctu_pkg::KIND_CURVE, idx, g);
    chk("curve busy_o", 1, busy_o);
    exp_cmd(ctu_pkg::CURVE_CMD, ctu_pkg::CURVE_CMD_LAST, ctu_pkg::CURVE_DIGIT, idx, g, 1'b1);
    send_line(nm);
    exp_line(xnm, g);
    send_line("Diode");
    exp_line("Diode", g);
    send_line("-1.0");
    exp_line("-1.0", g);
    send_line(un);
    exp_line(un, g);
    for (int i = 0; i < n; i++) begin
      send_line("0.34295 300.1205");
      exp_line("0.34295 300.1205", g);
    end
    exp_line(";", g);
    finish_upload("curve", 1'b1, st);
    chk("curve terminator", t0 + 1, ctu_dev_model_i.term_cnt);
  endtask
  task automatic sc_table(logic [7:0] idx, logic g, int n, logic [5:0] st, string a, string b);
    int t0;
    int l0;
    t0 = ctu_dev_model_i.term_cnt;
    l0 = ctu_dev_model_i.line_cnt;
    do_start(ctu_pkg::KIND_TABLE, idx, g);
    chk("table busy_o", 1, busy_o);
    exp_cmd(ctu_pkg::TABLE_CMD, ctu_pkg::LONG_CMD_LAST, ctu_pkg::TABLE_DIGIT, idx, g, 1'b1);
    send_line("Sixteen chars 16");
    exp_line("Sixteen chars 16", g);
    for (int i = 0; i < n; i++) begin
      send_line(i[0] ? b : a);
      if (i < 16) exp_line(i[0] ? b : a, g);
    end
    exp_line(";", g);
    finish_upload("table", 1'b1, st);
    chk("table terminator", t0 + 1, ctu_dev_model_i.term_cnt);
    // Command, name and terminator lines plus the entries kept
    chk("table lines", l0 + 3 + ((n > int'(ctu_pkg::TABLE_ENT_MAX)) ?
        int'(ctu_pkg::TABLE_ENT_MAX) : n), ctu_dev_model_i.line_cnt);
  endtask
  task automatic sc_sensor(logic g);
    do_start(ctu_pkg::KIND_SENSOR, 8'h03, g);
    chk("sensor busy_o", 1, busy_o);
    exp_cmd(ctu_pkg::SENSOR_CMD, ctu_pkg::LONG_CMD_LAST, ctu_pkg::SENSOR_DIGIT, 8'h03, g, 1'b0);
    send_line("User Curve 2");
    exp_line("User Curve 2\"", g);
    finish_upload("sensor", 1'b0, 6'h00);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn_i = 1'b0;
    start_i = 1'b0;
    kind_i = ctu_pkg::KIND_CURVE;
    index_i = 8'h00;
    gpib_i = 1'b0;
    u_valid_i = 1'b0;
    u_data_i = 8'h00;
    u_last_i = 1'b0;
    fin_i = 1'b0;
    slow = 1'b0;
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    @(negedge clk_i);
    sc_bad_index();
    slow = 1'b1;
    sc_curve(8'h04, 1'b0, "Good Diode 0123", "Good Diode 0123", "volts", 2, 6'h00);
    slow = 1'b0;
    sc_curve(8'h01, 1'b1, "Sixteen_chars_ab", "Sixteen_chars_b", "amps", 1, 6'h1c);
    sc_curve(8'h02, 1'b1, "abc", "abc", "Log_resistance_units", 2, 6'h10);
    sc_table(8'h00, 1'b1, 3, 6'h00, "300 1.6 160 40 HI", "20\t0.2 20 0 low");
    sc_table(8'h05, 1'b0, 17, 6'h01, "180 1 100 20 Mid", "10 0.1 10 0 LOW");
    sc_table(8'h02, 1'b0, 2, 6'h02, "1 2 3 4 x", "5 6 7 8");
    sc_sensor(1'b0);
    sc_sensor(1'b1);
    summarize();
  end
endmodule
